/* File: verilog/dsstx_pkg.sv */
/*
 * Constants for the DSSS transmit modulator: preamble layout, scrambler
 * seeds, spreading word, CCK chip count, chip-rate divider and FIR taps.
 * Assumes a 100 MHz system clock; chips are emitted at 11 Mchip/s.
 */
// Summary of operation
// RULE1: preamble, header and payload bits all go through the scrambler unless it is bypassed.
// RULE2: the scrambler is self-synchronizing, a 7-bit shift register with fixed feedback taps.
// RULE3: bit 2 of scrambler_config_reg set to one bypasses the scrambler.
// RULE4: the rate switches by itself after the DBPSK preamble when header or payload differ.
// RULE5: payload rates 1, 2, 5.5 and 11 Mbps use DBPSK, DQPSK and CCK.
// RULE6: every mode produces separate I and Q output streams.
// RULE7: in DBPSK mode I and Q carry the same scrambled, differentially encoded bit; after a DQPSK header the reference phase can be odd, and I and Q then differ.
// RULE8: DBPSK and DQPSK symbols are spread by the 11-chip Barker word at chip rate.
// RULE9: in DQPSK mode the bit stream is grouped into consecutive pairs.
// RULE10: of each DQPSK pair one encoded bit drives I and the other drives Q.
// RULE11: the output passes through a digital FIR filter set by tap coefficients.
// RULE12: bit 5 of tx_filter_config_reg selects the wider-main-lobe filter shape.
// RULE13: preamble is always DBPSK, header DBPSK or DQPSK, payload DBPSK, DQPSK or CCK.
// RULE14: long preamble is 128 ones then the delimiter, all at 1 Mbps.
// RULE15: short preamble is 56 zeros and the reversed delimiter at 1 Mbps, header at 2 Mbps.
// RULE16: scrambler polynomial and CCK mapping follow the 802.11 DSSS definition.
// RULE17: the differential phase reference runs on across preamble, header and payload.
package dsstx_pkg;
	typedef enum logic [1:0] {
		DSSTX_R1 = 2'h0,
		DSSTX_R2 = 2'h1,
		DSSTX_R55 = 2'h2,
		DSSTX_R11 = 2'h3
	} dsstx_rate_e;

	typedef enum logic [4:0] {
		DSSTX_IDLE = 5'h01,
		DSSTX_PRE = 5'h02,
		DSSTX_HDR = 5'h04,
		DSSTX_PAY = 5'h08,
		DSSTX_TAIL = 5'h10
	} dsstx_state_e;

	localparam int SCR_BYPASS_BIT = 2;
	localparam int FILT_WIDE_BIT = 5;
	localparam int SCR_TAP_A = 3;
	localparam int SCR_TAP_B = 6;
	localparam logic [6:0] SEED_LONG = 7'h1B;
	localparam logic [6:0] SEED_SHORT = 7'h6C;

	localparam logic [7:0] SYNC_LONG = 8'h80;
	localparam logic [7:0] SYNC_SHORT = 8'h38;
	localparam logic [7:0] SFD_BITS = 8'h10;
	localparam logic [15:0] SFD_LONG = 16'hF3A0;
	localparam logic [15:0] SFD_SHORT = 16'h05CF;
	localparam logic [7:0] HDR_BITS = 8'h30;

	localparam logic [10:0] BARKER = 11'h0ED;
	localparam logic [3:0] BARKER_LEN = 4'hB;
	localparam logic [3:0] CCK_LEN = 4'h8;

	localparam int CLK_MHZ = 100;
	localparam int CHIP_MHZ = 11;
	localparam logic [6:0] ACC_STEP = 7'(CHIP_MHZ);
	localparam logic [6:0] ACC_WRAP = 7'(CLK_MHZ);

	localparam int FIR_TAPS = 5;
	localparam logic [2:0] FLUSH_CHIPS = 3'(FIR_TAPS);
	localparam logic signed [7:0] TAP_STD [FIR_TAPS] =
		'{8'sh08, 8'sh20, 8'sh30, 8'sh20, 8'sh08};
	localparam logic signed [7:0] TAP_WIDE [FIR_TAPS] =
		'{8'sh00, 8'sh18, 8'sh40, 8'sh18, 8'sh00};
endpackage : dsstx_pkg

/* File: verilog/dsstx_modulator.sv */
/*
 * DSSS transmit modulator: preamble generator, scrambler, DBPSK/DQPSK
 * encoder with Barker spreading, CCK encoder and chip-rate FIR on I and Q.
 * Assumes the MAC keeps a bit ready whenever bit_ready_o is high; a word
 * short of bits at its symbol boundary waits with zero chips sent, and only
 * the last word of a packet is sent padded with zeros.
 */
`timescale 1ns/1ps
`default_nettype none

module dsstx_modulator (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic tx_start_i,
	input wire logic short_preamble_i,
	input wire logic header_dqpsk_i,
	input wire logic [1:0] payload_rate_i,
	input wire logic [7:0] scrambler_config_reg_i,
	input wire logic [7:0] tx_filter_config_reg_i,
	input wire logic bit_valid_i,
	input wire logic bit_i,
	input wire logic bit_last_i,
	output logic bit_ready_o,
	output logic busy_o,
	output logic [1:0] mode_o,
	output logic tx_strobe_o,
	output logic signed [9:0] tx_i_o,
	output logic signed [9:0] tx_q_o
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [1:0] dq_phase(input logic b0, input logic b1);
		logic [1:0] p;
		p = 2'h0;
		case ({b0, b1})
			2'b00: p = 2'h0;
			2'b01: p = 2'h1;
			2'b11: p = 2'h2;
			default: p = 2'h3;
		endcase
		return p;
	endfunction : dq_phase

	function automatic logic [1:0] cck_chip(input logic [2:0] k,
		input logic [1:0] p1, input logic [1:0] p2,
		input logic [1:0] p3, input logic [1:0] p4);
		logic [1:0] p;
		p = p1;
		case (k)
			3'h0: p = p1 + p2 + p3 + p4;
			3'h1: p = p1 + p3 + p4;
			3'h2: p = p1 + p2 + p4;
			3'h3: p = p1 + p4 + 2'h2;
			3'h4: p = p1 + p2 + p3;
			3'h5: p = p1 + p3;
			3'h6: p = p1 + p2 + 2'h2;
			default: p = p1;
		endcase
		return p;
	endfunction : cck_chip

	function automatic logic [3:0] word_need(input logic [1:0] r);
		logic [3:0] n;
		n = 4'h1;
		case (r)
			dsstx_pkg::DSSTX_R2: n = 4'h2;
			dsstx_pkg::DSSTX_R55: n = 4'h4;
			dsstx_pkg::DSSTX_R11: n = 4'h8;
			default: n = 4'h1;
		endcase
		return n;
	endfunction : word_need

	function automatic logic signed [9:0] fir_sum(input logic [9:0] h,
		input logic wide);
		logic signed [9:0] acc;
		logic signed [1:0] s;
		acc = 10'sh000;
		s = 2'sb00;
		for (int t = 0; t < dsstx_pkg::FIR_TAPS; t++) begin
			s = $signed(h[2*t +: 2]);
			acc = acc + 10'(s * (wide ? dsstx_pkg::TAP_WIDE[t]
				: dsstx_pkg::TAP_STD[t]));
		end
		return acc;
	endfunction : fir_sum

	////////////////////////////////////////////////////////////////////////
	// chip-rate enable, 11 pulses per 100 clocks

	logic [6:0] acc;
	logic chip_en;
	logic [6:0] next_acc;

	always_comb begin
		next_acc = acc + dsstx_pkg::ACC_STEP;
		chip_en = next_acc >= dsstx_pkg::ACC_WRAP;
		if (chip_en) begin
			next_acc = next_acc - dsstx_pkg::ACC_WRAP;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			acc <= 7'h00;
		end else begin
			acc <= next_acc;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// packet sequencer and bit collector

	dsstx_pkg::dsstx_state_e state;
	logic short_pre;
	logic hdr_dq;
	logic [1:0] pay_rate;
	logic [7:0] seg;
	logic [6:0] scr;
	logic [7:0] word;
	logic [3:0] wcnt;
	logic wfull;
	logic [1:0] wrate;
	logic take_word;
	logic pkt_done;
	logic [1:0] cur_rate;
	logic [7:0] sync_len;
	logic [15:0] sfd;
	logic pre_bit;
	logic have_bit;
	logic raw_bit;
	logic scr_bit;
	logic seg_end;

	always_comb begin
		sync_len = short_pre ? dsstx_pkg::SYNC_SHORT : dsstx_pkg::SYNC_LONG; // RULE14 RULE15
		sfd = short_pre ? dsstx_pkg::SFD_SHORT : dsstx_pkg::SFD_LONG;
		pre_bit = (seg < sync_len) ? ~short_pre : sfd[4'(seg - sync_len)];
		cur_rate = dsstx_pkg::DSSTX_R1; // RULE13
		if (state == dsstx_pkg::DSSTX_HDR && hdr_dq) begin
			cur_rate = dsstx_pkg::DSSTX_R2; // RULE4
		end else if (state == dsstx_pkg::DSSTX_PAY) begin
			cur_rate = pay_rate; // RULE4 RULE5
		end
		bit_ready_o = !wfull && (state == dsstx_pkg::DSSTX_HDR
			|| state == dsstx_pkg::DSSTX_PAY);
		have_bit = (!wfull && state == dsstx_pkg::DSSTX_PRE)
			|| (bit_ready_o && bit_valid_i);
		raw_bit = (state == dsstx_pkg::DSSTX_PRE) ? pre_bit : bit_i;
		scr_bit = raw_bit; // RULE3
		if (!scrambler_config_reg_i[dsstx_pkg::SCR_BYPASS_BIT]) begin
			scr_bit = raw_bit ^ scr[dsstx_pkg::SCR_TAP_A]
				^ scr[dsstx_pkg::SCR_TAP_B]; // RULE1 RULE2 RULE16
		end
		seg_end = (state == dsstx_pkg::DSSTX_PRE
			&& seg == sync_len + dsstx_pkg::SFD_BITS - 8'h01)
			|| (state == dsstx_pkg::DSSTX_HDR
			&& seg == dsstx_pkg::HDR_BITS - 8'h01);
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state <= dsstx_pkg::DSSTX_IDLE;
			short_pre <= 1'b0;
			hdr_dq <= 1'b0;
			pay_rate <= dsstx_pkg::DSSTX_R1;
			seg <= 8'h00;
		end else begin
			case (state)
				dsstx_pkg::DSSTX_IDLE: begin
					if (tx_start_i) begin
						state <= dsstx_pkg::DSSTX_PRE;
						short_pre <= short_preamble_i;
						hdr_dq <= header_dqpsk_i | short_preamble_i; // RULE15
						pay_rate <= payload_rate_i;
						seg <= 8'h00;
					end
				end
				dsstx_pkg::DSSTX_PRE, dsstx_pkg::DSSTX_HDR: begin
					if (have_bit) begin
						seg <= seg_end ? 8'h00 : seg + 8'h01;
						if (seg_end) begin
							state <= (state == dsstx_pkg::DSSTX_PRE)
								? dsstx_pkg::DSSTX_HDR : dsstx_pkg::DSSTX_PAY;
						end
					end
				end
				dsstx_pkg::DSSTX_PAY: begin
					if (have_bit && bit_last_i) begin
						state <= dsstx_pkg::DSSTX_TAIL;
					end
				end
				default: begin
					if (pkt_done) begin
						state <= dsstx_pkg::DSSTX_IDLE;
					end
				end
			endcase
		end
	end

	// scrambler register and word assembly
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			scr <= 7'h00;
			word <= 8'h00;
			wcnt <= 4'h0;
			wfull <= 1'b0;
			wrate <= dsstx_pkg::DSSTX_R1;
		end else begin
			if (state == dsstx_pkg::DSSTX_IDLE && tx_start_i) begin
				scr <= short_preamble_i ? dsstx_pkg::SEED_SHORT
					: dsstx_pkg::SEED_LONG;
			end else if (have_bit) begin
				scr <= {scr[5:0], scr_bit}; // RULE2
			end
			if (take_word) begin
				wfull <= 1'b0;
				wcnt <= 4'h0;
				word <= 8'h00;
			end else if (have_bit) begin
				word[wcnt[2:0]] <= scr_bit; // RULE9
				wcnt <= wcnt + 4'h1;
				wrate <= cur_rate;
				wfull <= (wcnt + 4'h1 == word_need(cur_rate))
					|| (state == dsstx_pkg::DSSTX_PAY && bit_last_i);
			end else if (state == dsstx_pkg::DSSTX_TAIL && wcnt != 4'h0) begin
				wfull <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// symbol encoder and chip generator

	logic sym_on;
	logic [3:0] chip_idx;
	logic [1:0] sym_rate;
	logic [1:0] ref_ph;
	logic [1:0] p2;
	logic [1:0] p3;
	logic [1:0] p4;
	logic cck_odd;
	logic [1:0] chip_ph;
	logic chip_live;
	logic [2:0] flush;
	logic sym_end;
	logic [1:0] next_ref;
	logic [3:0] sym_len;

	always_comb begin
		sym_len = (sym_rate[1]) ? dsstx_pkg::CCK_LEN : dsstx_pkg::BARKER_LEN;
		sym_end = !sym_on || chip_idx == sym_len - 4'h1;
		take_word = chip_en && sym_end && wfull;
		next_ref = ref_ph;
		case (wrate)
			dsstx_pkg::DSSTX_R1: next_ref = ref_ph + {word[0], 1'b0}; // RULE7
			dsstx_pkg::DSSTX_R2: next_ref = ref_ph + dq_phase(word[0], word[1]);
			default: next_ref = ref_ph + dq_phase(word[0], word[1])
				+ {cck_odd, 1'b0}; // RULE16
		endcase
		pkt_done = chip_en && sym_end && !wfull && flush == 3'h0
			&& state == dsstx_pkg::DSSTX_TAIL && wcnt == 4'h0;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sym_on <= 1'b0;
			chip_idx <= 4'h0;
			sym_rate <= dsstx_pkg::DSSTX_R1;
			ref_ph <= 2'h0;
			p2 <= 2'h0;
			p3 <= 2'h0;
			p4 <= 2'h0;
			cck_odd <= 1'b0;
		end else if (state == dsstx_pkg::DSSTX_IDLE) begin
			sym_on <= 1'b0;
			// next preamble reports DBPSK from its first strobe
			sym_rate <= dsstx_pkg::DSSTX_R1; // RULE13
			ref_ph <= 2'h0;
			cck_odd <= 1'b0;
		end else if (take_word) begin
			sym_on <= 1'b1;
			chip_idx <= 4'h0;
			sym_rate <= wrate;
			ref_ph <= next_ref; // RULE17
			cck_odd <= wrate[1] ? ~cck_odd : cck_odd;
			p2 <= dq_phase(word[2], word[3]) ^ {1'b0, word[2]};
			p3 <= word[5:4];
			p4 <= {word[6], word[7]};
			if (wrate == dsstx_pkg::DSSTX_R55) begin
				p2 <= {word[2], 1'b1};
				p3 <= 2'h0;
				p4 <= {word[3], 1'b0};
			end else if (wrate == dsstx_pkg::DSSTX_R11) begin
				p2 <= {word[2], word[3]};
				p3 <= {word[4], word[5]};
			end
		end else if (chip_en) begin
			if (sym_end) begin
				sym_on <= 1'b0;
			end else begin
				chip_idx <= chip_idx + 4'h1;
			end
		end
	end

	always_comb begin
		chip_live = sym_on;
		chip_ph = ref_ph;
		if (sym_rate[1]) begin
			chip_ph = cck_chip(chip_idx[2:0], ref_ph, p2, p3, p4); // RULE5 RULE16
		end else if (!dsstx_pkg::BARKER[chip_idx]) begin
			chip_ph = ref_ph + 2'h2; // RULE8
		end
	end

	////////////////////////////////////////////////////////////////////////
	// chip-rate FIR on I and Q, flushed after the last symbol

	logic [9:0] hist_i;
	logic [9:0] hist_q;
	logic signed [1:0] ci;
	logic signed [1:0] cq;
	logic wide;

	always_comb begin
		// quadrant to I/Q: phases 1,2 give I<0 and 2,3 give Q<0
		ci = !chip_live ? 2'sb00 : (chip_ph == 2'h1 || chip_ph == 2'h2)
			? 2'sb11 : 2'sb01; // RULE6 RULE10
		cq = !chip_live ? 2'sb00 : chip_ph[1] ? 2'sb11 : 2'sb01;
		wide = tx_filter_config_reg_i[dsstx_pkg::FILT_WIDE_BIT]; // RULE12
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			hist_i <= 10'h000;
			hist_q <= 10'h000;
			tx_i_o <= 10'sh000;
			tx_q_o <= 10'sh000;
			tx_strobe_o <= 1'b0;
			flush <= 3'h0;
		end else begin
			tx_strobe_o <= chip_en && state != dsstx_pkg::DSSTX_IDLE;
			if (chip_en) begin
				hist_i <= {hist_i[7:0], ci};
				hist_q <= {hist_q[7:0], cq};
				tx_i_o <= fir_sum({hist_i[7:0], ci}, wide); // RULE11
				tx_q_o <= fir_sum({hist_q[7:0], cq}, wide);
				if (chip_live) begin
					flush <= dsstx_pkg::FLUSH_CHIPS;
				end else if (flush != 3'h0) begin
					flush <= flush - 3'h1;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			busy_o <= 1'b0;
			mode_o <= dsstx_pkg::DSSTX_R1;
		end else begin
			busy_o <= state != dsstx_pkg::DSSTX_IDLE;
			mode_o <= sym_rate;
		end
	end

endmodule : dsstx_modulator

`default_nettype wire

/* File: verif/dsstx_mod_properties.sv */
/* Port checker for dsstx_modulator.
 * Bound to the design top; watches its ports only. */
`timescale 1ns/1ps
`default_nettype none
module dsstx_mod_properties (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic tx_start_i,
	input wire logic bit_ready_o,
	input wire logic busy_o,
	input wire logic [1:0] mode_o,
	input wire logic tx_strobe_o,
	input wire logic signed [9:0] tx_i_o,
	input wire logic signed [9:0] tx_q_o
);
	localparam int PRE_MIN = 770;
	logic [11:0] chips;
	logic pre;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// chips since the last accepted start
	always_ff @(posedge clk_i) begin
		if (reset_i || (tx_start_i && !busy_o))
			chips <= 12'h000;
		else if (tx_strobe_o && chips != 12'hFFF)
			chips <= chips + 12'h001;
	end
	assign pre = busy_o && (chips < 12'(PRE_MIN));
	sequence s_start;
		tx_start_i && !busy_o;
	endsequence
	sequence s_gap;
		(!tx_strobe_o) [*8];
	endsequence
	// busy is registered from the state, so it shows one edge later
	AST_START_BUSY: assert property (s_start |=> ##1 busy_o)
		else $error("start not taken");
	AST_STROBE_GAP: assert property (tx_strobe_o |=> s_gap)
		else $error("chip strobes too close");
	AST_STROBE_RATE: assert property (busy_o && tx_strobe_o |->
		##[9:10] (tx_strobe_o || !busy_o)) else $error("chip strobe late");
	AST_PRE_DBPSK: assert property (pre && tx_strobe_o |->
		mode_o == dsstx_pkg::DSSTX_R1) else $error("preamble not DBPSK");
	AST_PRE_IQ: assert property (pre && tx_strobe_o |->
		tx_i_o == tx_q_o) else $error("DBPSK I and Q differ");
	AST_PRE_NO_DATA: assert property (pre |-> !bit_ready_o)
		else $error("bits asked during preamble");
	AST_IDLE_QUIET: assert property (!busy_o |-> !bit_ready_o &&
		tx_i_o == 10'sh000 && tx_q_o == 10'sh000) else $error("idle not quiet");
	AST_HOLD: assert property (busy_o && !tx_strobe_o |->
		$stable(tx_i_o) && $stable(tx_q_o)) else $error("output moved off chip");
	AST_RESET_CLEAR: assert property ($fell(reset_i) |-> !busy_o &&
		!tx_strobe_o && mode_o == 2'h0) else $error("reset left state");
endmodule : dsstx_mod_properties
bind dsstx_modulator dsstx_mod_properties i_props (.clk_i, .reset_i,
	.tx_start_i, .bit_ready_o, .busy_o, .mode_o, .tx_strobe_o, .tx_i_o,
	.tx_q_o);
`default_nettype wire

/* File: verif/dsstx_mac_model.sv */
/* MAC-side bit source for the transmit modulator.
 * Loaded with a bit count and pattern; answers every ready at once. */
`timescale 1ns/1ps
`default_nettype none
module dsstx_mac_model (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic load_i,
	input wire logic [6:0] count_i,
	input wire logic [63:0] data_i,
	input wire logic ready_i,
	output logic valid_o,
	output logic bit_o,
	output logic last_o,
	output var logic [6:0] taken_o
);
	logic [6:0] left;
	logic [63:0] pat;
	assign valid_o = left != 7'h00;
	assign last_o = left == 7'h01;
	assign bit_o = pat[0];
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			left <= 7'h00;
			taken_o <= 7'h00;
			pat <= 64'h0;
		end else if (load_i) begin
			left <= count_i;
			taken_o <= 7'h00;
			pat <= data_i;
		end else if (valid_o && ready_i) begin
			left <= left - 7'h01;
			taken_o <= taken_o + 7'h01;
			pat <= {pat[0] ^ pat[5], pat[63:1]};
		end else if (!valid_o) begin
			pat <= ~pat; // released line keeps moving
		end
	end
endmodule : dsstx_mac_model
`default_nettype wire

/* File: verif/dsstx_testbench.sv */
/* Self-checking bench for dsstx_modulator with a MAC bit source.
 * Needs dsstx_pkg, the checker and dsstx_mac_model. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic tx_start_i = 1'b0;
	logic sp = 1'b0;
	logic hd = 1'b0;
	logic [1:0] rt = 2'h0;
	logic [7:0] scr = 8'h00;
	logic [7:0] flt = 8'h00;
	logic ld = 1'b0;
	logic [6:0] cnt = 7'h00;
	logic [63:0] dat = 64'h0;
	logic valid, bt, last, ready, busy, strobe;
	logic [1:0] mode;
	logic [6:0] taken;
	logic signed [9:0] ti, tq;
	logic [31:0] lfsr = 32'h1830;
	int err_count = 0;
	int tests_run = 0;
	always #5 clk_i = ~clk_i;
	dsstx_modulator i_dut (.clk_i, .reset_i, .tx_start_i,
		.short_preamble_i(sp), .header_dqpsk_i(hd), .payload_rate_i(rt),
		.scrambler_config_reg_i(scr), .tx_filter_config_reg_i(flt),
		.bit_valid_i(valid), .bit_i(bt), .bit_last_i(last), .bit_ready_o(ready),
		.busy_o(busy), .mode_o(mode), .tx_strobe_o(strobe), .tx_i_o(ti),
		.tx_q_o(tq));
	dsstx_mac_model i_mac (.clk_i, .reset_i, .load_i(ld), .count_i(cnt),
		.data_i(dat), .ready_i(ready), .valid_o(valid), .bit_o(bt),
		.last_o(last), .taken_o(taken));
	function automatic logic [31:0] lfsr_next();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : lfsr_next
	// strobes of a packet: one dead strobe as the first word is taken,
	// the symbol chips, then five flush chips and the closing strobe
	function automatic int exp_chips(input logic s, h, input logic [1:0] r,
		input int n);
		int c;
		c = ((s ? 72 : 144) + ((s | h) ? 24 : 48)) * 11;
		case (r)
			2'h0: c += n * 11;
			2'h1: c += (n + 1) / 2 * 11;
			2'h2: c += (n + 3) / 4 * 8;
			default: c += (n + 7) / 8 * 8;
		endcase
		return c + 7;
	endfunction : exp_chips
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	task automatic run_pkt(input logic s, h, b, w, input logic [1:0] r,
		input int n);
		int k, t, sum;
		logic signed [9:0] hist [600];
		logic per, anti, iqd;
		logic [3:0] seen;
		k = 0;
		sum = 0;
		per = 1'b1;
		anti = 1'b1;
		iqd = 1'b0;
		seen = 4'h0;
		sp = s;
		hd = h;
		rt = r;
		scr = {5'h00, b, 2'h0};
		flt = {2'h0, w, 5'h00};
		cnt = 7'(48 + n);
		dat = {lfsr_next(), lfsr_next()};
		ld = 1'b1;
		tx_start_i = 1'b1;
		@(posedge clk_i);
		#1;
		ld = 1'b0;
		tx_start_i = 1'b0;
		// busy follows the state register one clock later
		@(posedge clk_i);
		#1;
		check("busy start", busy, 1'b1);
		for (t = 0; t < 40000 && busy === 1'b1; t++) begin
			// a strobe at t=0 comes before any word is ready: not counted
			if (strobe === 1'b1 && t != 0) begin
				if (k >= 20 && k < 600) begin
					per &= ti === hist[k - 11];
					anti &= ti === -hist[k - 11];
				end
				if (k < 600)
					hist[k] = ti;
				if (k >= 100 && k < 111)
					sum += ti;
				iqd |= ti !== tq;
				seen[mode] = 1'b1;
				k++;
			end
			tx_start_i = t == 50; // refused while busy
			@(posedge clk_i);
			#1;
		end
		check("busy end", busy, 1'b0);
		if (busy !== 1'b0)
			give_verdict();
		check("chips", k, exp_chips(s, h, r, n));
		check("bits taken", taken, 48 + n);
		check("mode end", mode, r);
		check("modes", seen, 4'h1 | (4'h1 << (s | h)) | (4'h1 << r));
		check("iq split", iqd, s | h | (r != 2'h0));
		if (b)
			check("periodic", s ? per : anti, 1'b1);
		else
			check("scrambled", per | anti, 1'b0);
		if (b && s)
			check("fir sum", sum < 0 ? -sum : sum, w ? 112 : 128);
		$display("packet rate %0d length %0d done", r, n);
	endtask : run_pkt
	initial begin
		repeat (4) @(posedge clk_i);
		#1;
		reset_i = 1'b0;
		run_pkt(0, 0, 1, 0, 2'h0, 16);
		run_pkt(1, 1, 1, 0, 2'h1, 1 + lfsr_next() % 40);
		run_pkt(1, 0, 1, 1, 2'h2, 21);
		run_pkt(0, 1, 0, 0, 2'h3, 1 + lfsr_next() % 79);
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
